// ---- logic/port_pkg.sv ----
// Package: register map, reset values and widths for the 8-bit port
package port_pkg;
  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int unsigned PORT_WIDTH = 8;
  localparam int unsigned ADDR_WIDTH = 4;
  localparam int unsigned EXT_ADDR_PINS = 4;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [3:0] OFF_PORT_DIRECTION = 4'h0;
  localparam logic [3:0] OFF_PORT_PIN_VALUE = 4'h1;
  localparam logic [3:0] OFF_PORT_OUTPUT_LATCH = 4'h2;
  localparam logic [3:0] OFF_MEMORY_INTERFACE_CONTROL = 4'h3;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int unsigned EXT_BUS_DISABLE_BIT = 7;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] RST_PORT_DIRECTION = 8'hFF;
  localparam logic [7:0] RST_PORT_OUTPUT_LATCH = 8'h00;
  localparam logic [7:0] RST_MEMORY_INTERFACE_CONTROL = 8'h80;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;
endpackage

// ---- logic/pin_sync.sv ----
// Two-flop synchroniser for the port pin levels
module pin_sync
  import port_pkg::*;
(
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [PORT_WIDTH-1:0] async_in,
  output logic [PORT_WIDTH-1:0] sync_out
);
  logic [PORT_WIDTH-1:0] meta_ff;
  logic [PORT_WIDTH-1:0] sync_ff;

  // ----------------------------------------
  // Synchroniser stages
  // ----------------------------------------
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meta_ff <= 8'h00;
      sync_ff <= 8'h00;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;
endmodule

// ---- logic/pin_mux.sv ----
// Per-pin output mux: latch data or external address, with direction override
module pin_mux
  import port_pkg::*;
(
  input wire logic [PORT_WIDTH-1:0] dir_in,
  input wire logic [PORT_WIDTH-1:0] latch_in,
  input wire logic [EXT_ADDR_PINS-1:0] ext_addr_in,
  input wire logic ext_en_in,
  output logic [PORT_WIDTH-1:0] drive_out,
  output logic [PORT_WIDTH-1:0] oe_out
);
  // ----------------------------------------
  // One slice per pin
  // ----------------------------------------
  for (genvar i = 0; i < PORT_WIDTH; i++) begin : g_pin
    if (i < EXT_ADDR_PINS) begin : g_addr
      // Address wins over latch and direction
      assign drive_out[i] = ext_en_in ? ext_addr_in[i] : latch_in[i];
      assign oe_out[i] = ext_en_in | ~dir_in[i];
    end else begin : g_plain
      // No alternate function here
      assign drive_out[i] = latch_in[i];
      assign oe_out[i] = ~dir_in[i];
    end
  end
endmodule

// ---- logic/gpio_port.sv ----
// Top: 8-bit bidirectional port with external address override on pins 0..3
//
// Chosen here: the address map and strobed register access.

// How it works
// - The port has eight pins, each pin controlled by one bit in each of the direction, pin value and output latch registers.
// - A direction bit of 1 turns that pin's driver off so the pin is an input.
// - A direction bit of 0 drives the pin with its output latch bit.
// - The output latch register is addressable and reads back latch contents, not pins.
// - Each pin's direction is set independently of the others.
// - After reset every direction bit is set so all pins are inputs.
// - With the memory interface enabled, pins 0 to 3 carry address bits 16 to 19.
// - While the address is on pins 0 to 3, their direction bits are ignored.
// - The address outputs take precedence over any other function of those pins.
// - Clearing the bus disable bit in the memory control register enables the interface.
module gpio_port
  import port_pkg::*;
(
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [ADDR_WIDTH-1:0] addr_in,
  input wire logic [PORT_WIDTH-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [PORT_WIDTH-1:0] rdata_out,
  input wire logic [EXT_ADDR_PINS-1:0] ext_addr_in,
  input wire logic [PORT_WIDTH-1:0] pin_in,
  output logic [PORT_WIDTH-1:0] pin_out,
  output logic [PORT_WIDTH-1:0] pin_oe_out,
  output logic ext_bus_enabled_out
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [PORT_WIDTH-1:0] port_direction_ff;
  logic [PORT_WIDTH-1:0] nxt_port_direction;
  logic [PORT_WIDTH-1:0] port_output_latch_ff;
  logic [PORT_WIDTH-1:0] nxt_port_output_latch;
  logic [PORT_WIDTH-1:0] memory_interface_control_ff;
  logic [PORT_WIDTH-1:0] nxt_memory_interface_control;
  logic [PORT_WIDTH-1:0] rdata_ff;
  logic [PORT_WIDTH-1:0] nxt_rdata;
  logic [PORT_WIDTH-1:0] pin_out_ff;
  logic [PORT_WIDTH-1:0] pin_oe_ff;
  logic ext_en_ff;
  logic [PORT_WIDTH-1:0] pin_sampled;
  logic [PORT_WIDTH-1:0] mux_drive;
  logic [PORT_WIDTH-1:0] mux_oe;
  logic ext_en;

  // ----------------------------------------
  // Pin sampling
  // ----------------------------------------
  pin_sync u_sync (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .async_in(pin_in),
    .sync_out(pin_sampled)
  );

  // Interface is on while the disable bit is clear
  assign ext_en = ~memory_interface_control_ff[EXT_BUS_DISABLE_BIT];

  // ----------------------------------------
  // Register writes and reads
  // ----------------------------------------
  always_comb begin
    nxt_port_direction = port_direction_ff;
    nxt_port_output_latch = port_output_latch_ff;
    nxt_memory_interface_control = memory_interface_control_ff;
    nxt_rdata = rdata_ff;
    if (wr_in) begin
      case (addr_in)
        // Whole byte written, each bit its own pin
        OFF_PORT_DIRECTION: nxt_port_direction = wdata_in;
        // Pin-value writes land in the latch
        OFF_PORT_PIN_VALUE: nxt_port_output_latch = wdata_in;
        OFF_PORT_OUTPUT_LATCH: nxt_port_output_latch = wdata_in;
        OFF_MEMORY_INTERFACE_CONTROL: nxt_memory_interface_control = wdata_in;
        default: nxt_port_direction = port_direction_ff;
      endcase
    end
    if (rd_in) begin
      case (addr_in)
        OFF_PORT_DIRECTION: nxt_rdata = port_direction_ff;
        // Pin levels are two cycles old through the synchroniser
        OFF_PORT_PIN_VALUE: nxt_rdata = pin_sampled;
        // Latch, not pins, so read-modify-write is safe
        OFF_PORT_OUTPUT_LATCH: nxt_rdata = port_output_latch_ff;
        OFF_MEMORY_INTERFACE_CONTROL: nxt_rdata = memory_interface_control_ff;
        default: nxt_rdata = RD_UNMAPPED;
      endcase
    end else begin
      nxt_rdata = RD_UNMAPPED;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      port_direction_ff <= RST_PORT_DIRECTION;
      port_output_latch_ff <= RST_PORT_OUTPUT_LATCH;
      memory_interface_control_ff <= RST_MEMORY_INTERFACE_CONTROL;
      rdata_ff <= RD_UNMAPPED;
    end else begin
      port_direction_ff <= nxt_port_direction;
      port_output_latch_ff <= nxt_port_output_latch;
      memory_interface_control_ff <= nxt_memory_interface_control;
      rdata_ff <= nxt_rdata;
    end
  end

  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  pin_mux u_mux (
    .dir_in(port_direction_ff),
    .latch_in(port_output_latch_ff),
    .ext_addr_in(ext_addr_in),
    .ext_en_in(ext_en),
    .drive_out(mux_drive),
    .oe_out(mux_oe)
  );

  // Registered outputs add one cycle of latency on the pins
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pin_out_ff <= 8'h00;
      pin_oe_ff <= 8'h00;
      ext_en_ff <= 1'b0;
    end else begin
      pin_out_ff <= mux_drive;
      pin_oe_ff <= mux_oe;
      ext_en_ff <= ext_en;
    end
  end

  assign rdata_out = rdata_ff;
  assign pin_out = pin_out_ff;
  assign pin_oe_out = pin_oe_ff;
  assign ext_bus_enabled_out = ext_en_ff;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  a_input_high_z: assert property (
    (port_direction_ff[7:4] == 4'hF) |=> (pin_oe_out[7:4] == 4'h0))
    else $error("input pins still driven");
  a_output_latch: assert property (
    (!ext_en && port_direction_ff == 8'h00) |=> (pin_out == $past(port_output_latch_ff)))
    else $error("output pin differs from latch");
  a_latch_readback: assert property (
    (rd_in && addr_in == OFF_PORT_OUTPUT_LATCH) |=> (rdata_out == $past(port_output_latch_ff)))
    else $error("latch readback wrong");
  a_dir_independent: assert property (
    (wr_in && addr_in == OFF_PORT_DIRECTION) |=> (port_direction_ff == $past(wdata_in)))
    else $error("direction write not taken");
  a_reset_inputs: assert property (
    $rose(nrst_in) |-> (port_direction_ff == RST_PORT_DIRECTION))
    else $error("pins not inputs after reset");
  a_addr_override: assert property (
    ext_en |=> (pin_out[3:0] == $past(ext_addr_in)))
    else $error("address bits not on pins 0..3");
  a_addr_dir_ignored: assert property (
    ext_en |=> (pin_oe_out[3:0] == 4'hF))
    else $error("address pins not driven");
  a_enable_bit: assert property (
    (wr_in && addr_in == OFF_MEMORY_INTERFACE_CONTROL && !wdata_in[EXT_BUS_DISABLE_BIT])
      |=> ##1 ext_bus_enabled_out)
    else $error("interface not enabled by clearing disable bit");
  a_pin_value_read: assert property (
    (rd_in && addr_in == OFF_PORT_PIN_VALUE) |=> (rdata_out == $past(pin_sampled)))
    else $error("pin value read wrong");
  a_upper_plain: assert property (
    ext_en |=> (pin_oe_out[7:4] == ~$past(port_direction_ff[7:4])))
    else $error("upper pins affected by interface");
  a_upper_drive: assert property (
    ext_en |=> (pin_out[7:4] == $past(port_output_latch_ff[7:4])))
    else $error("upper pins not driven from latch");
  a_lower_dir: assert property (
    !ext_en |=> (pin_oe_out[3:0] == ~$past(port_direction_ff[3:0])))
    else $error("lower pins ignore direction while interface off");
  // Read data stand one cycle only, so a stale value cannot be taken twice
  a_rdata_idle: assert property (
    !rd_in |=> (rdata_out == RD_UNMAPPED))
    else $error("read data not cleared");
  a_dir_readback: assert property (
    (rd_in && addr_in == OFF_PORT_DIRECTION) |=> (rdata_out == $past(port_direction_ff)))
    else $error("direction readback wrong");
  a_latch_write: assert property (
    (wr_in && addr_in == OFF_PORT_OUTPUT_LATCH) |=> (port_output_latch_ff == $past(wdata_in)))
    else $error("latch write not taken");
  a_pin_write_latch: assert property (
    (wr_in && addr_in == OFF_PORT_PIN_VALUE) |=> (port_output_latch_ff == $past(wdata_in)))
    else $error("pin-value write missed the latch");
  a_ctrl_readback: assert property (
    (rd_in && addr_in == OFF_MEMORY_INTERFACE_CONTROL)
      |=> (rdata_out == $past(memory_interface_control_ff)))
    else $error("control readback wrong");
  a_disable_bit: assert property (
    (wr_in && addr_in == OFF_MEMORY_INTERFACE_CONTROL && wdata_in[EXT_BUS_DISABLE_BIT])
      |=> ##1 !ext_bus_enabled_out)
    else $error("interface not disabled by setting disable bit");
  // Unmapped writes must not alias onto a real register
  a_unmapped_wr: assert property (
    (wr_in && addr_in > OFF_MEMORY_INTERFACE_CONTROL)
      |=> ($stable(port_direction_ff) && $stable(port_output_latch_ff)))
    else $error("unmapped write changed a register");

  c_ext_enable: cover property (ext_en ##1 ext_bus_enabled_out);
  c_latch_write: cover property (wr_in && addr_in == OFF_PORT_OUTPUT_LATCH);
  c_pin_read: cover property (rd_in && addr_in == OFF_PORT_PIN_VALUE);
  c_all_outputs: cover property (port_direction_ff == 8'h00);
  c_pin_write: cover property (wr_in && addr_in == OFF_PORT_PIN_VALUE);
endmodule

// ---- bench/pin_model.sv ----
// Partner model: external circuitry resolving the levels seen on the port pins
module pin_model
  import port_pkg::*;
(
  input wire logic [PORT_WIDTH-1:0] drive_in,
  input wire logic [PORT_WIDTH-1:0] oe_in,
  input wire logic [PORT_WIDTH-1:0] ext_in,
  output logic [PORT_WIDTH-1:0] level_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Pin resolution
  // ----------------------------------------
  // No pulls: a released pin shows only what the outside circuit drives
  always_comb begin
    for (int i = 0; i < PORT_WIDTH; i++) begin
      level_out[i] = oe_in[i] ? drive_in[i] : ext_in[i];
    end
  end
endmodule

// ---- bench/eight_bit_port_with_address_override_tb_top.sv ----
// Testbench: register access, direction, latch and address override checks
module eight_bit_port_with_address_override_tb_top;
  import port_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clk_in, nrst_in, wr_in, rd_in;
  logic [ADDR_WIDTH-1:0] addr_in;
  logic [PORT_WIDTH-1:0] wdata_in, rdata_out, pin_in, pin_out, pin_oe_out, ext_val;
  logic [EXT_ADDR_PINS-1:0] ext_addr_in;
  logic ext_bus_enabled_out;
  int num_errors = 0;
  int n_checks = 0;
  gpio_port uut (.clk_in(clk_in), .nrst_in(nrst_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .ext_addr_in(ext_addr_in),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_out(pin_oe_out),
    .ext_bus_enabled_out(ext_bus_enabled_out));
  pin_model far (.drive_in(pin_out), .oe_in(pin_oe_out), .ext_in(ext_val), .level_out(pin_in));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  // Read data exist only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    d = rdata_out;
    @(posedge clk_in);
    #1;
    check(rdata_out, 8'h00);
  endtask
  task automatic settle();
    repeat (3) @(posedge clk_in);
    #1;
  endtask
  task automatic complete_run();
    if (num_errors == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Clock, watchdog
  // ----------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  initial begin
    #(20 * 3000);
    num_errors++;
    complete_run();
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    logic [7:0] d;
    nrst_in = 1'b0; wr_in = 1'b0; rd_in = 1'b0; addr_in = 4'h0; wdata_in = 8'h00;
    ext_addr_in = 4'hA; ext_val = 8'hA5;
    repeat (4) @(posedge clk_in);
    nrst_in <= 1'b1;
    settle();
    check(pin_oe_out, 8'h00);
    check({7'h00, ext_bus_enabled_out}, 8'h00);
    rd(OFF_PORT_DIRECTION, d); check(d, 8'hFF);
    rd(OFF_MEMORY_INTERFACE_CONTROL, d); check(d, 8'h80);
    rd(OFF_PORT_PIN_VALUE, d); check(d, 8'hA5);
    wr(OFF_PORT_OUTPUT_LATCH, 8'h5A);
    // Walk a single output through all eight pins
    for (int i = 0; i < 8; i++) begin
      wr(OFF_PORT_DIRECTION, ~(8'h01 << i));
      settle();
      check(pin_oe_out, 8'h01 << i);
      check(pin_out & pin_oe_out, 8'h5A & (8'h01 << i));
    end
    wr(OFF_PORT_DIRECTION, 8'h00);
    settle();
    check(pin_out, 8'h5A);
    rd(OFF_PORT_OUTPUT_LATCH, d); check(d, 8'h5A);
    wr(OFF_PORT_DIRECTION, 8'hFF);
    settle();
    rd(OFF_PORT_OUTPUT_LATCH, d); check(d, 8'h5A);
    rd(OFF_PORT_PIN_VALUE, d); check(d, 8'hA5);
    wr(OFF_PORT_PIN_VALUE, 8'h3C);
    rd(OFF_PORT_OUTPUT_LATCH, d); check(d, 8'h3C);
    wr(4'h5, 8'h77);
    rd(4'h5, d); check(d, 8'h00);
    rd(OFF_PORT_DIRECTION, d); check(d, 8'hFF);
    // Enable the memory interface with all pins still marked as inputs
    wr(OFF_MEMORY_INTERFACE_CONTROL, 8'h00);
    settle();
    check({7'h00, ext_bus_enabled_out}, 8'h01);
    check(pin_oe_out, 8'h0F);
    check({4'h0, pin_out[3:0]}, 8'h0A);
    wr(OFF_PORT_DIRECTION, 8'h0F);
    ext_addr_in <= 4'h5;
    settle();
    check(pin_oe_out, 8'hFF);
    check(pin_out, 8'h35);
    wr(OFF_MEMORY_INTERFACE_CONTROL, 8'h80);
    settle();
    check({7'h00, ext_bus_enabled_out}, 8'h00);
    check(pin_oe_out, 8'hF0);
    complete_run();
  end
endmodule
